/* src/fsm_pkg.sv */
package fsm_pkg;

  // Register location and field layout of the flash space control register.
  localparam logic [7:0] FSM_CTRL_ADDR = 8'h00_D1;
  localparam int FSM_BUSY_BIT = 0;
  localparam int FSM_SEL_LSB = 1;
  localparam int FSM_MAP_BIT = 3;
  localparam int FSM_KEY_LSB = 4;
  localparam logic [7:0] FSM_CTRL_RESET = 8'h00_00;

  // Space select encodings.
  typedef enum logic [1:0] {
    FSM_SPACE_APP = 2'b00,
    FSM_SPACE_SIG = 2'b01,
    FSM_SPACE_FUSE = 2'b10,
    FSM_SPACE_RSVD = 2'b11
  } fsm_space_e;

  // Launch key nibbles.
  localparam logic [3:0] FSM_KEY_ARM = 4'h5;
  localparam logic [3:0] FSM_KEY_GO = 4'hA;

  // Code-space window limits.
  localparam logic [15:0] FSM_USIG_LAST = 16'h01FF;
  localparam logic [15:0] FSM_FSIG_LAST = 16'h027F;
  localparam logic [15:0] FSM_UFUSE_LAST = 16'h007F;
  localparam logic [15:0] FSM_HSEC_LAST = 16'h00FF;

  // Boot addresses and the soft vector value meaning no customer loader.
  localparam logic [15:0] FSM_LOADER_ENTRY = 16'hF800;
  localparam logic [15:0] FSM_APP_ENTRY = 16'h0000;
  localparam logic [15:0] FSM_SERVICE_ENTRY = 16'hFFF0;
  localparam logic [7:0] FSM_SBV_NONE = 8'h00_FC;

  // Programming time, nominally 10 ms, at a 50 MHz clock.
  localparam int FSM_CLK_MHZ = 50;
  localparam int FSM_PROG_TIME_US = 10000;
  localparam int FSM_PROG_CYCLES = FSM_PROG_TIME_US * FSM_CLK_MHZ;

  // Code read request towards the space multiplexer.
  typedef struct packed {
    logic valid;
    logic [15:0] addr;
  } fsm_code_req_s;

  // Code read answer: data and which array supplied it.
  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic [2:0] source;
  } fsm_code_rsp_s;

  localparam logic [2:0] FSM_SRC_APP = 3'h0;
  localparam logic [2:0] FSM_SRC_USIG = 3'h1;
  localparam logic [2:0] FSM_SRC_FSIG = 3'h2;
  localparam logic [2:0] FSM_SRC_UFUSE = 3'h3;
  localparam logic [2:0] FSM_SRC_HSEC = 3'h4;
  localparam logic [2:0] FSM_SRC_NONE = 3'h7;

endpackage

/* src/fsm_flash_space_map.sv */
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// RULE1 - Select 01 maps user signature to 0-01FF, factory signature to 0200-027F.
// RULE2 - Select 10 maps user fuses to 0-007F, security bits to 0080-00FF.
// RULE3 - Software clears the control register afterwards to see application code again.
// RULE4 - Select codes: 00 application, 01 signatures, 10 fuses and security, 11 reserved.
// RULE5 - Control register sits at direct address D1, not bit addressable, resets zero.
// RULE6 - Key nibble 5 then A launches programming on the selected space.
// RULE7 - Map bit set sends data-move writes to page buffer, else to data memory.
// RULE8 - Busy bit is hardware owned: set while programming, cleared when done.
// RULE9 - Strobe pin low when reset releases forces the on-chip loader.
// RULE10 - Strobe pin sampled only at the reset release edge.
// RULE11 - Pin-forced loader overrides jump fuse, boot status and soft vector.
// RULE12 - Jump fuse zero selects the loader, one selects the application.
// RULE13 - Soft vector holds customer loader high byte; FC means none exists.
// RULE14 - Flash services reached through one common entry point in loader.
// RULE15 - External logic releases the strobe pin after the reset release edge.
// RULE16 - External logic should not ground the strobe pin during power-on.
// RULE17 - On-chip loader turns serial frames into flash read, write and erase.
// RULE18 - The two key writes must be back to back or launch aborts.
// RULE19 - Brown-out during programming sets the error flag in data memory control.
// RULE20 - Key sequence with reserved select starts nothing and leaves busy clear.
module fsm_flash_space_map
  import fsm_pkg::*;
#(
  parameter int PROG_CYCLES = FSM_PROG_CYCLES
) (
  input wire logic clock,
  input wire logic arst_n,
  // Special-function register port from the core.
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  output logic sfr_hit,
  // One pulse per executed instruction, used to police the key pair.
  input wire logic insn_done,
  // Code read path.
  input wire fsm_code_req_s code_req,
  input wire logic [7:0] app_rdata,
  input wire logic [7:0] usig_rdata,
  input wire logic [7:0] fsig_rdata,
  input wire logic [7:0] ufuse_rdata,
  input wire logic [7:0] hsec_rdata,
  output fsm_code_rsp_s code_rsp,
  // External data-move writes.
  input wire logic xwr_valid,
  input wire logic [15:0] xwr_addr,
  input wire logic [7:0] xwr_data,
  output logic pbuf_wr,
  output logic xram_wr,
  output logic [15:0] xwr_addr_q,
  output logic [7:0] xwr_data_q,
  // Programming engine handshake.
  output logic prog_start,
  output logic [1:0] prog_space,
  input wire logic brown_out,
  output logic prog_error,
  // Boot selection.
  input wire logic reset_pin,
  input wire logic reset_polarity_setting,
  input wire logic program_store_strobe_pin,
  input wire logic loader_jump_fuse,
  input wire logic [7:0] soft_boot_vector,
  output logic boot_to_loader,
  output logic [15:0] boot_addr,
  output logic [15:0] service_entry,
  output logic customer_loader_present
);

  // A programming time below one cycle would wrap the down-counter.
  if (PROG_CYCLES < 1) begin : g_bad_prog_cycles
    $error("PROG_CYCLES must be at least one");
  end

  // Release the reset through two flops.
  // Assertion stays asynchronous, so the block is quiet even while the clock is stopped.
  logic rst_s1_r;
  logic rst_n_r;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r <= rst_s1_r;
    end
  end

  // Control register fields, key pair state and programming down-counter.
  logic [3:0] launch_key_bits_r;
  logic page_buffer_map_select_r;
  fsm_space_e space_select_field_r;
  logic program_in_progress_flag_r;
  logic key_armed_r;
  logic [31:0] prog_cnt_r;

  // Write and read of the control register share one address decode.
  function automatic logic is_ctrl(input logic [7:0] a);
    return a == FSM_CTRL_ADDR;
  endfunction

  // Launch key nibble of a written byte.
  function automatic logic [3:0] key_nibble(input logic [7:0] d);
    return d[7:FSM_KEY_LSB];
  endfunction

  // Space select field of a written byte; a launch takes it from the go write itself.
  function automatic logic [1:0] sel_field(input logic [7:0] d);
    return d[FSM_SEL_LSB +: 2];
  endfunction

  logic ctrl_wr;
  logic ctrl_rd;
  assign ctrl_wr = sfr_wr && is_ctrl(sfr_addr); // [RULE5]
  assign ctrl_rd = sfr_rd && is_ctrl(sfr_addr); // [RULE5]

  // Software writable fields; busy is not among them.
  always_ff @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      launch_key_bits_r <= FSM_CTRL_RESET[7:FSM_KEY_LSB]; // [RULE5]
      page_buffer_map_select_r <= FSM_CTRL_RESET[FSM_MAP_BIT];
      space_select_field_r <= FSM_SPACE_APP;
    end else if (ctrl_wr) begin
      // Bit 0 of the written byte is dropped, so software cannot touch busy.
      launch_key_bits_r <= key_nibble(sfr_wdata);
      page_buffer_map_select_r <= sfr_wdata[FSM_MAP_BIT];
      space_select_field_r <= fsm_space_e'(sel_field(sfr_wdata)); // [RULE4]
    end
  end

  // Key pair tracking: any other instruction between the two writes disarms it.
  logic key_arm_wr;
  logic key_go_wr;
  assign key_arm_wr = ctrl_wr && (key_nibble(sfr_wdata) == FSM_KEY_ARM);
  assign key_go_wr = ctrl_wr && (key_nibble(sfr_wdata) == FSM_KEY_GO);
  // The arming write carries no insn_done of its own; only a later instruction disarms.
  always_ff @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      key_armed_r <= 1'b0;
    end else if (key_arm_wr) begin
      key_armed_r <= 1'b1; // [RULE6]
    end else if (ctrl_wr || insn_done) begin
      key_armed_r <= 1'b0; // [RULE18]
    end
  end

  // Launch happens on the second key when armed and the target is legal.
  logic launch;
  // A launch while busy is refused, so the counter is never reloaded in mid-run.
  assign launch = key_go_wr && key_armed_r && !program_in_progress_flag_r
    && (sel_field(sfr_wdata) != FSM_SPACE_RSVD); // [RULE6] [RULE20]

  // Busy flag and programming timer, owned by hardware only.
  always_ff @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      program_in_progress_flag_r <= 1'b0;
      prog_cnt_r <= 32'h0000_0000;
      prog_start <= 1'b0;
      prog_space <= 2'b00;
    end else begin
      prog_start <= launch;
      if (launch) begin
        program_in_progress_flag_r <= 1'b1; // [RULE8]
        prog_cnt_r <= 32'(PROG_CYCLES - 1);
        prog_space <= sel_field(sfr_wdata); // [RULE6]
      end else if (program_in_progress_flag_r) begin
        if (brown_out || prog_cnt_r == 32'h0000_0000) begin
          program_in_progress_flag_r <= 1'b0; // [RULE8]
        end else begin
          prog_cnt_r <= prog_cnt_r - 32'h0000_0001;
        end
      end
    end
  end

  // Sticky error when brown-out cuts programming short; only reset clears it.
  // Brown-out outside a programming run leaves the flag alone.
  always_ff @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      prog_error <= 1'b0;
    end else if (program_in_progress_flag_r && brown_out) begin
      prog_error <= 1'b1; // [RULE19]
    end
  end

  // Register read-back; other addresses are not claimed so other blocks may answer.
  // Idle read data is zero, so several read buses can be merged by a plain OR.
  always_ff @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      sfr_rdata <= 8'h00_00;
      sfr_hit <= 1'b0;
    end else begin
      sfr_hit <= ctrl_rd;
      if (ctrl_rd) begin
        sfr_rdata <= {launch_key_bits_r, page_buffer_map_select_r,
          space_select_field_r, program_in_progress_flag_r};
      end else begin
        sfr_rdata <= 8'h00_00;
      end
    end
  end

  // Pick the array for a code read; outside a window nothing answers.
  function automatic logic [2:0] code_source(input fsm_space_e sel, input logic [15:0] a);
    logic [2:0] s;
    s = FSM_SRC_NONE;
    unique case (sel)
      FSM_SPACE_APP: s = FSM_SRC_APP;
      FSM_SPACE_SIG: begin
        if (a <= FSM_USIG_LAST) s = FSM_SRC_USIG; // [RULE1]
        else if (a <= FSM_FSIG_LAST) s = FSM_SRC_FSIG;
      end
      FSM_SPACE_FUSE: begin
        if (a <= FSM_UFUSE_LAST) s = FSM_SRC_UFUSE; // [RULE2]
        else if (a <= FSM_HSEC_LAST) s = FSM_SRC_HSEC;
      end
      FSM_SPACE_RSVD: s = FSM_SRC_NONE;
    endcase
    return s;
  endfunction

  // Registered code read answer; unmapped reads return all ones.
  logic [2:0] src;
  assign src = code_source(space_select_field_r, code_req.addr);
  always_ff @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      code_rsp <= '0;
    end else begin
      code_rsp.valid <= code_req.valid;
      code_rsp.source <= src;
      unique case (src)
        FSM_SRC_APP: code_rsp.data <= app_rdata;
        FSM_SRC_USIG: code_rsp.data <= usig_rdata;
        FSM_SRC_FSIG: code_rsp.data <= fsig_rdata;
        FSM_SRC_UFUSE: code_rsp.data <= ufuse_rdata;
        FSM_SRC_HSEC: code_rsp.data <= hsec_rdata;
        default: code_rsp.data <= 8'h00_FF;
      endcase
    end
  end

  // Steer data-move writes by the map bit.
  // Address and data are registered for both targets; only the strobes differ.
  always_ff @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pbuf_wr <= 1'b0;
      xram_wr <= 1'b0;
      xwr_addr_q <= 16'h0000;
      xwr_data_q <= 8'h00_00;
    end else begin
      pbuf_wr <= xwr_valid && page_buffer_map_select_r; // [RULE7]
      xram_wr <= xwr_valid && !page_buffer_map_select_r; // [RULE7]
      xwr_addr_q <= xwr_addr;
      xwr_data_q <= xwr_data;
    end
  end

  // Watch the reset pin for its releasing edge; the pin is taken as synchronous.
  // The first clock after reset only loads the delay flop: its reset value would
  // otherwise fake a rising release whenever an active-low pin already idles high.
  // If the pin never toggles after reset, no choice is made and the application entry stays.
  logic reset_pin_d_r;
  logic pin_primed_r;
  logic boot_done_r;
  logic pin_release;
  assign pin_release = pin_primed_r
    && (reset_polarity_setting ? (reset_pin_d_r && !reset_pin)
    : (!reset_pin_d_r && reset_pin)); // [RULE9]

  always_ff @(posedge clock or negedge rst_n_r) begin
    if (!rst_n_r) begin
      reset_pin_d_r <= 1'b0;
      pin_primed_r <= 1'b0;
      boot_done_r <= 1'b0;
      boot_to_loader <= 1'b0;
      boot_addr <= FSM_APP_ENTRY;
      service_entry <= FSM_SERVICE_ENTRY;
      customer_loader_present <= 1'b0;
    end else begin
      reset_pin_d_r <= reset_pin;
      pin_primed_r <= 1'b1;
      service_entry <= FSM_SERVICE_ENTRY; // [RULE14]
      customer_loader_present <= soft_boot_vector != FSM_SBV_NONE; // [RULE13]
      // Decide once at the first release edge and ignore the pin afterwards.
      if (pin_release && !boot_done_r) begin
        boot_done_r <= 1'b1; // [RULE10]
        if (!program_store_strobe_pin) begin
          boot_to_loader <= 1'b1; // [RULE9] [RULE11]
          boot_addr <= FSM_LOADER_ENTRY; // [RULE17]
        end else if (!loader_jump_fuse) begin
          boot_to_loader <= 1'b1; // [RULE12]
          boot_addr <= FSM_LOADER_ENTRY;
        end else begin
          boot_to_loader <= 1'b0; // [RULE12]
          boot_addr <= FSM_APP_ENTRY;
        end
      end
    end
  end

endmodule // fsm_flash_space_map
`default_nettype wire

/* bench/fsm_array_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Stand-in for the five nonvolatile arrays behind the code read path.
module fsm_array_model
  import fsm_pkg::*;
(
  input wire logic [15:0] addr,
  output logic [7:0] app_rdata,
  output logic [7:0] usig_rdata,
  output logic [7:0] fsig_rdata,
  output logic [7:0] ufuse_rdata,
  output logic [7:0] hsec_rdata
);
  // Each array folds the address with its own pattern, so a wrong source shows.
  assign app_rdata = addr[7:0] ^ 8'h00_3C;
  assign usig_rdata = addr[7:0] ^ 8'h00_5A;
  assign fsig_rdata = addr[7:0] ^ 8'h00_66;
  assign ufuse_rdata = addr[7:0] ^ 8'h00_81;
  assign hsec_rdata = addr[7:0] ^ 8'h00_C3;
endmodule // fsm_array_model
`default_nettype wire

/* bench/fsm_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
// Port-level timing checks for the flash space block.
module fsm_monitor
  import fsm_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_rd,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_hit,
  input wire fsm_code_req_s code_req,
  input wire fsm_code_rsp_s code_rsp,
  input wire logic xwr_valid,
  input wire logic [15:0] xwr_addr,
  input wire logic pbuf_wr,
  input wire logic xram_wr,
  input wire logic [15:0] xwr_addr_q,
  input wire logic prog_start,
  input wire logic [1:0] prog_space,
  input wire logic boot_to_loader,
  input wire logic [15:0] boot_addr,
  input wire logic [15:0] service_entry
);
  // One clock domain, so clock and reset are stated once.
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  hit_pulse_a: assert property (sfr_rd && sfr_addr == FSM_CTRL_ADDR |=> sfr_hit)
    else $error("control register read gave no hit");
  hit_quiet_a: assert property (!(sfr_rd && sfr_addr == FSM_CTRL_ADDR) |=> !sfr_hit)
    else $error("control register hit without a read");
  start_cause_a: assert property (
    prog_start |-> $past(sfr_wr && sfr_addr == FSM_CTRL_ADDR && sfr_wdata[7:4] == FSM_KEY_GO))
    else $error("launch without a go key write");
  start_pulse_a: assert property (prog_start |=> !prog_start)
    else $error("launch pulse too long");
  no_reserved_a: assert property (prog_start |-> prog_space != 2'b11)
    else $error("launch on reserved space");
  xwr_route_a: assert property (
    xwr_valid |=> (pbuf_wr != xram_wr) && xwr_addr_q == $past(xwr_addr))
    else $error("data move write misrouted");
  xwr_quiet_a: assert property (!xwr_valid |=> !pbuf_wr && !xram_wr)
    else $error("spurious data move write");
  code_answer_a: assert property (code_req.valid |=> code_rsp.valid)
    else $error("code read not answered");
  entry_fixed_a: assert property (service_entry == FSM_SERVICE_ENTRY)
    else $error("service entry moved");
  loader_addr_a: assert property (boot_to_loader |-> boot_addr == FSM_LOADER_ENTRY)
    else $error("loader boot at wrong address");
  app_addr_a: assert property (!boot_to_loader |-> boot_addr == FSM_APP_ENTRY)
    else $error("application boot at wrong address");
endmodule // fsm_monitor
bind fsm_flash_space_map fsm_monitor u_mon (.clock, .arst_n, .sfr_addr, .sfr_rd, .sfr_wr,
  .sfr_wdata, .sfr_hit, .code_req, .code_rsp, .xwr_valid, .xwr_addr, .pbuf_wr, .xram_wr,
  .xwr_addr_q, .prog_start, .prog_space, .boot_to_loader, .boot_addr, .service_entry);
`default_nettype wire

/* bench/test_flash_space_map_boot_select.sv */
`timescale 1ns/1ps
`default_nettype none
module test_flash_space_map_boot_select
  import fsm_pkg::*;
  ;
  logic clock, arst_n, sfr_wr, sfr_rd, sfr_hit, insn_done, xwr_valid, pbuf_wr, xram_wr;
  logic prog_start, brown_out, prog_error, reset_pin, reset_polarity_setting;
  logic program_store_strobe_pin, loader_jump_fuse, boot_to_loader, customer_loader_present;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, xwr_data, xwr_data_q, soft_boot_vector;
  logic [7:0] app_rdata, usig_rdata, fsig_rdata, ufuse_rdata, hsec_rdata;
  logic [15:0] xwr_addr, xwr_addr_q, boot_addr, service_entry;
  logic [1:0] prog_space;
  fsm_code_req_s code_req;
  fsm_code_rsp_s code_rsp;
  int miscompares, total_checks, starts, n;
  localparam logic [7:0] PAT [5] = '{8'h00_3C, 8'h00_5A, 8'h00_66, 8'h00_81, 8'h00_C3};
  localparam logic [31:0] TBL [12] = '{32'h0200_0001, 32'h0201_FF01, 32'h0202_0002,
    32'h0202_7F02, 32'h0202_8007, 32'h0400_0003, 32'h0400_7F03, 32'h0400_8004,
    32'h0400_FF04, 32'h0401_0007, 32'h0600_0007, 32'h0012_3400};

  fsm_flash_space_map #(.PROG_CYCLES(20)) DUT (.clock, .arst_n, .sfr_addr, .sfr_wr, .sfr_rd,
    .sfr_wdata, .sfr_rdata, .sfr_hit, .insn_done, .code_req, .app_rdata, .usig_rdata,
    .fsig_rdata, .ufuse_rdata, .hsec_rdata, .code_rsp, .xwr_valid, .xwr_addr, .xwr_data,
    .pbuf_wr, .xram_wr, .xwr_addr_q, .xwr_data_q, .prog_start, .prog_space, .brown_out,
    .prog_error, .reset_pin, .reset_polarity_setting, .program_store_strobe_pin,
    .loader_jump_fuse, .soft_boot_vector, .boot_to_loader, .boot_addr, .service_entry,
    .customer_loader_present);
  fsm_array_model u_arr (.addr(code_req.addr), .app_rdata, .usig_rdata, .fsig_rdata,
    .ufuse_rdata, .hsec_rdata);

  // Clock and a running count of launches, so refused keys are visible.
  always #10 clock = !clock;
  always @(posedge clock) if (prog_start === 1'b1) starts++;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic idle(input int k);
    repeat (k) begin
      @(negedge clock);
      sfr_wr = 0;
      sfr_rd = 0;
      xwr_valid = 0;
      code_req.valid = 0;
    end
  endtask
  task automatic wr(input logic [7:0] d);
    @(negedge clock);
    insn_done = 0;
    sfr_addr = FSM_CTRL_ADDR;
    sfr_wdata = d;
    sfr_wr = 1;
  endtask
  task automatic rd(input logic [7:0] a);
    idle(1);
    sfr_addr = a;
    sfr_rd = 1;
    idle(1);
  endtask
  // Reset with a chosen boot setup, release reset_pin, then let the strobe pin go.
  task automatic boot(input logic p, s, f, input logic [7:0] v, input logic l);
    arst_n = 0;
    reset_pin = p;
    reset_polarity_setting = p;
    program_store_strobe_pin = s;
    loader_jump_fuse = f;
    soft_boot_vector = v;
    idle(16);
    arst_n = 1;
    idle(4);
    reset_pin = !p;
    idle(2);
    program_store_strobe_pin = 1;
    idle(3);
    chk(boot_to_loader, l);
    chk(boot_addr, l ? FSM_LOADER_ENTRY : FSM_APP_ENTRY);
    chk(customer_loader_present, v != FSM_SBV_NONE);
    chk(service_entry, FSM_SERVICE_ENTRY);
  endtask
  task automatic tally_and_finish;
    if (miscompares == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Main sequence.
  initial begin
    {clock, sfr_wr, sfr_rd, insn_done, xwr_valid, brown_out} = '0;
    {sfr_addr, sfr_wdata, xwr_addr, code_req} = '0;
    xwr_data = 8'h00_5A;
    boot(1, 1, 1, 8'h00_40, 0);
    boot(1, 1, 0, FSM_SBV_NONE, 1);
    boot(1, 0, 1, FSM_SBV_NONE, 1);
    boot(0, 0, 1, 8'h00_40, 1);
    rd(FSM_CTRL_ADDR);
    chk(sfr_rdata, 0);
    chk(sfr_hit, 1);
    rd(8'h00_D0);
    chk(sfr_hit, 0);
    for (int i = 0; i < 12; i++) begin
      wr(TBL[i][31:24]);
      idle(1);
      code_req.valid = 1;
      code_req.addr = TBL[i][23:8];
      idle(1);
      chk(code_rsp.source, TBL[i][2:0]);
      chk(code_rsp.data, TBL[i][2:0] == 7 ? 8'h00_FF : TBL[i][15:8] ^ PAT[TBL[i][2:0]]);
    end
    for (int b = 0; b < 2; b++) begin
      wr({4'h0, !b[0], 3'b000});
      idle(1);
      xwr_valid = 1;
      xwr_addr = 16'h0040 + b;
      xwr_data = b[0] ? 8'h00_A5 : 8'h00_5A;
      idle(1);
      chk(xwr_data_q, b[0] ? 8'h00_A5 : 8'h00_5A);
      chk(pbuf_wr, !b[0]);
      chk(xram_wr, b[0]);
      chk(xwr_addr_q, 16'h0040 + b);
    end
    for (int m = 0; m < 3; m++) begin
      wr({FSM_KEY_ARM, 1'b0, m[1:0], 1'b0});
      wr({FSM_KEY_GO, 1'b0, m[1:0], 1'b0});
      idle(1);
      chk(prog_start, 1);
      chk(prog_space, m[1:0]);
      rd(FSM_CTRL_ADDR);
      chk(sfr_rdata[0], 1);
      idle(25);
      rd(FSM_CTRL_ADDR);
      chk(sfr_rdata[0], 0);
    end
    n = starts;
    wr(8'h00_52);
    idle(1);
    insn_done = 1;
    wr(8'h00_A2);
    wr(8'h00_56);
    wr(8'h00_A6);
    wr(8'h00_A0);
    wr(8'h00_01);
    rd(FSM_CTRL_ADDR);
    chk(sfr_rdata, 8'h00_00);
    idle(2);
    chk(starts, n);
    wr(8'h00_50);
    wr(8'h00_A0);
    idle(5);
    brown_out = 1;
    idle(2);
    brown_out = 0;
    rd(FSM_CTRL_ADDR);
    chk(sfr_rdata[0], 0);
    chk(prog_error, 1);
    tally_and_finish();
  end
  // Watchdog: the sequence needs well under a thousand cycles.
  initial begin
    repeat (5000) @(posedge clock);
    miscompares++;
    tally_and_finish();
  end
endmodule // test_flash_space_map_boot_select
`default_nettype wire
